// ==== logic/tsq_consts.svh ====
// Constants of the touch converter serial sequencer
`ifndef TSQ_CONSTS_SVH
`define TSQ_CONSTS_SVH
// Command word bit positions, most significant bit first on the line
`define TSQ_CMD_BITS     8
`define TSQ_CMD_START    7
`define TSQ_CMD_CH_HI    6
`define TSQ_CMD_CH_LO    4
`define TSQ_CMD_MODE     3
`define TSQ_CMD_SD       2
`define TSQ_CMD_REFPWR   1
`define TSQ_CMD_ADCPWR   0
`define TSQ_CMD_RESET    8'h00
// Serial clock edge numbers counted from the start bit
`define TSQ_RISE_REFPWR  5'h07
`define TSQ_RISE_ADCPWR  5'h08
`define TSQ_FALL_TRACK   5'h05
`define TSQ_FALL_BUSY    5'h08
`define TSQ_FALL_MSB     5'h09
// Result widths and codes
`define TSQ_CODE_W       12
`define TSQ_BITS_FULL    5'h0C
`define TSQ_BITS_SHORT   5'h08
`define TSQ_CODE_ZERO    12'h000
`define TSQ_FIFO_DEPTH   4
`endif

// ==== logic/tsq_pkg.sv ====
// Types of the touch converter serial sequencer
`default_nettype none
package tsq_pkg;
  typedef enum logic {TSQ_HUNT, TSQ_RUN} tsq_state_t;
  typedef enum logic [2:0] {TSQ_AIN_TEMP0, TSQ_AIN_XP, TSQ_AIN_VBAT, TSQ_AIN_YN,
                            TSQ_AIN_YP, TSQ_AIN_IN1, TSQ_AIN_TEMP1, TSQ_AIN_IN2} tsq_ain_t;
  typedef enum logic [1:0] {TSQ_NEG_GND, TSQ_NEG_YN, TSQ_NEG_XN} tsq_neg_t;
  typedef enum logic [1:0] {TSQ_REF_VREF, TSQ_REF_YP_YN, TSQ_REF_YP_XN, TSQ_REF_XP_XN} tsq_ref_t;
endpackage
`default_nettype wire

// ==== logic/tsq_sequencer.sv ====
// Serial command sequencer of the touch converter, with its result FIFO
// What this block does
// - Result is unsigned straight binary, twelve bits (top eight in short mode), zero to all ones.
// - Every conversion is driven by an eight-bit serial command word.
// - Channel bits and single/differential bit pick input and plate drivers.
// - Differential axis mode: full scale is measured axis drive, ratiometric.
// - Single-ended mode: full scale is the reference voltage against ground.
// - Second auxiliary input is always measured single-ended against reference.
// - Input tracked from falling edge five to falling edge eight.
// - Drivers stay on through conversion in differential, tracking only otherwise.
// - Command: start, channel, resolution, single/differential, two power bits.
// - Command bits sampled on serial clock rising edges while selected.
// - Busy high only between falling edges eight and nine; floats deselected.
// - Result MSB at busy fall, then shifts on falling edges; else low.
`default_nettype none
`include "tsq_consts.svh"

// ----------------------------------------------------------------
// Result FIFO
// ----------------------------------------------------------------
module tsq_fifo #(
  parameter int WIDTH = `TSQ_CODE_W,
  parameter int DEPTH = `TSQ_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------------------------------
// Sequencer top
// ----------------------------------------------------------------
module tsq_sequencer (
  // Clock, reset, enable
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  // Serial pins
  input  wire logic                  serial_clk,
  input  wire logic                  chip_sel_n,
  input  wire logic                  cmd_in,
  output logic                       busy_out,
  output logic                       busy_oe,
  output logic                       result_out,
  output logic                       result_oe,
  // Plate drivers
  output logic                       x_plus,
  output logic                       x_minus,
  output logic                       y_plus,
  output logic                       y_minus,
  // Analog front end control
  output tsq_pkg::tsq_ain_t          ain_pos_sel,
  output tsq_pkg::tsq_neg_t          ain_neg_sel,
  output tsq_pkg::tsq_ref_t          ref_sel,
  output logic                       track_en,
  output logic                       conv_start,
  output logic                       ref_power_bit,
  output logic                       adc_power_bit,
  // Converted codes from the front end
  input  wire logic                  code_valid,
  output logic                       code_ready,
  input  wire logic [`TSQ_CODE_W-1:0] code_data
);
  import tsq_pkg::*;

  tsq_state_t state_q;
  logic       sclk_q;
  logic       rise;
  logic       fall;
  logic [4:0] rcnt_q;
  logic [4:0] fcnt_q;
  logic [7:0] cmd_q;
  logic [`TSQ_CODE_W-1:0] shift_q;
  logic [4:0] nbits;
  logic       diff;
  logic       drv_on_q;
  logic       head_valid;
  logic [`TSQ_CODE_W-1:0] head_data;
  logic       take;
  logic [2:0] ch;

  // Serial clock is synchronous to ref_clk, so one register gives both edges
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else if (ce) begin
      sclk_q <= serial_clk;
    end
  end
  assign rise  = serial_clk & ~sclk_q;
  assign fall  = ~serial_clk & sclk_q;
  assign ch    = cmd_q[`TSQ_CMD_CH_HI:`TSQ_CMD_CH_LO];
  assign diff  = ~cmd_q[`TSQ_CMD_SD];
  assign nbits = cmd_q[`TSQ_CMD_MODE] ? `TSQ_BITS_SHORT : `TSQ_BITS_FULL;
  assign take  = fall & (state_q == TSQ_RUN) & (fcnt_q == `TSQ_FALL_MSB - 5'h01);

  // ----------------------------------------------------------------
  // Framing and command capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= TSQ_HUNT;
      rcnt_q  <= '0;
      fcnt_q  <= '0;
      cmd_q   <= `TSQ_CMD_RESET;
    end else if (ce) begin
      if (chip_sel_n) begin
        state_q <= TSQ_HUNT;
        rcnt_q  <= '0;
        fcnt_q  <= '0;
      end else if (state_q == TSQ_HUNT) begin
        if (rise && cmd_in) begin
          state_q <= TSQ_RUN;
          rcnt_q  <= 5'h01;
          fcnt_q  <= '0;
          cmd_q   <= 8'h80;
        end
      end else begin
        if (rise && rcnt_q < 5'(`TSQ_CMD_BITS)) begin
          cmd_q[3'(7 - rcnt_q)] <= cmd_in;
          rcnt_q <= rcnt_q + 5'h01;
        end
        if (fall) begin
          fcnt_q <= fcnt_q + 5'h01;
          if (fcnt_q == `TSQ_FALL_BUSY + nbits) begin
            state_q <= TSQ_HUNT;
          end
        end
      end
    end
  end

  // Power bits update on rising edges seven and eight
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ref_power_bit <= 1'b0;
      adc_power_bit <= 1'b0;
    end else if (ce && !chip_sel_n && state_q == TSQ_RUN && rise) begin
      if (rcnt_q == `TSQ_RISE_REFPWR - 5'h01) begin
        ref_power_bit <= cmd_in;
      end
      if (rcnt_q == `TSQ_RISE_ADCPWR - 5'h01) begin
        adc_power_bit <= cmd_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tracking, busy and plate drivers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      track_en   <= 1'b0;
      busy_out   <= 1'b0;
      drv_on_q   <= 1'b0;
      conv_start <= 1'b0;
    end else if (ce) begin
      conv_start <= 1'b0;
      if (chip_sel_n || state_q == TSQ_HUNT) begin
        track_en <= 1'b0;
        busy_out <= 1'b0;
        drv_on_q <= 1'b0;
      end else if (fall) begin
        if (fcnt_q == `TSQ_FALL_TRACK - 5'h01) begin
          track_en <= 1'b1;
          drv_on_q <= 1'b1;
        end
        if (fcnt_q == `TSQ_FALL_BUSY - 5'h01) begin
          track_en   <= 1'b0;
          busy_out   <= 1'b1;
          conv_start <= 1'b1;
          drv_on_q   <= diff;
        end
        if (fcnt_q == `TSQ_FALL_MSB - 5'h01) begin
          busy_out <= 1'b0;
        end
        if (fcnt_q == `TSQ_FALL_BUSY + nbits) begin
          drv_on_q <= 1'b0;
        end
      end
    end
  end

  // Driver and input selection per channel; unusable differential codes idle
  always_comb begin
    {x_plus, x_minus, y_plus, y_minus} = 4'h0;
    ain_pos_sel = tsq_ain_t'(ch);
    ain_neg_sel = TSQ_NEG_GND;
    ref_sel     = TSQ_REF_VREF;
    case (ch)
      3'h1: begin
        {y_plus, y_minus} = {2{drv_on_q}};
        if (diff) begin
          ain_neg_sel = TSQ_NEG_YN;
          ref_sel     = TSQ_REF_YP_YN;
        end
      end
      3'h3, 3'h4: begin
        {x_minus, y_plus} = {2{drv_on_q}};
        ain_pos_sel = ch[2] ? TSQ_AIN_YN : TSQ_AIN_XP;
        if (diff) begin
          ain_neg_sel = TSQ_NEG_XN;
          ref_sel     = TSQ_REF_YP_XN;
        end
      end
      3'h5: begin
        {x_plus, x_minus} = {2{drv_on_q}};
        ain_pos_sel = TSQ_AIN_YP;
        if (diff) begin
          ain_neg_sel = TSQ_NEG_XN;
          ref_sel     = TSQ_REF_XP_XN;
        end
      end
      3'h6: begin
        ain_pos_sel = diff ? TSQ_AIN_IN2 : TSQ_AIN_IN1;
      end
      3'h7: begin
        ain_pos_sel = TSQ_AIN_TEMP1;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Result path
  // ----------------------------------------------------------------
  tsq_fifo #(.WIDTH(`TSQ_CODE_W), .DEPTH(`TSQ_FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (code_valid),
    .in_ready  (code_ready),
    .in_data   (code_data),
    .out_valid (head_valid),
    .out_ready (take & ~chip_sel_n),
    .out_data  (head_data)
  );

  // An empty FIFO at busy fall sends zero rather than stalling the host clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shift_q    <= `TSQ_CODE_ZERO;
      result_out <= 1'b0;
    end else if (ce) begin
      if (chip_sel_n || state_q == TSQ_HUNT) begin
        result_out <= 1'b0;
      end else if (take) begin
        shift_q    <= head_valid ? head_data : `TSQ_CODE_ZERO;
        result_out <= head_valid & head_data[`TSQ_CODE_W-1];
      end else if (fall && fcnt_q >= `TSQ_FALL_MSB) begin
        shift_q    <= {shift_q[`TSQ_CODE_W-2:0], 1'b0};
        result_out <= (fcnt_q < `TSQ_FALL_BUSY + nbits) ? shift_q[`TSQ_CODE_W-2] : 1'b0;
      end
    end
  end

  assign busy_oe   = ~chip_sel_n;
  assign result_oe = ~chip_sel_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_busy_fall;
    ce && fall && state_q == TSQ_RUN && !chip_sel_n && fcnt_q == 5'h08;
  endsequence
  sequence s_track_start;
    ce && fall && state_q == TSQ_RUN && !chip_sel_n && fcnt_q == 5'h04;
  endsequence

  chk_busy_window: assert property (s_busy_fall |=> !busy_out)
    else $error("busy did not fall at falling edge nine");
  chk_busy_only_8: assert property ($rose(busy_out) |-> $past(fcnt_q) == 5'h07)
    else $error("busy rose away from falling edge eight");
  chk_track_open: assert property (s_track_start |=> track_en && drv_on_q)
    else $error("tracking did not open at falling edge five");
  chk_track_len: assert property ($fell(track_en) && !$past(chip_sel_n)
                                  |-> $past(fcnt_q) == 5'h07)
    else $error("tracking closed at the wrong edge");
  chk_single_drv: assert property ($rose(busy_out) && !diff |-> !drv_on_q)
    else $error("drivers left on during single-ended conversion");
  chk_diff_drv: assert property ($rose(busy_out) && diff |-> drv_on_q)
    else $error("drivers dropped during differential conversion");
  chk_deselect_idle: assert property (ce && chip_sel_n |=> state_q == TSQ_HUNT
                                      && !busy_out && !result_out)
    else $error("deselect did not abandon the transaction");
  chk_msb_out: assert property ((s_busy_fall and head_valid)
                                |=> result_out == $past(head_data[11]))
    else $error("MSB not presented at busy fall");
  chk_aux2_single: assert property (ch == 3'h6 && diff |-> ain_neg_sel == TSQ_NEG_GND
                                    && ref_sel == TSQ_REF_VREF && ain_pos_sel == TSQ_AIN_IN2)
    else $error("second auxiliary input not single-ended");
  chk_conv_pulse: assert property ($rose(busy_out) |-> conv_start ##1 !conv_start)
    else $error("conversion start not a single pulse at busy rise");
  chk_tristate: assert property (chip_sel_n |-> !busy_oe && !result_oe)
    else $error("outputs driven while deselected");
endmodule
`default_nettype wire

// ==== test/tsq_host.sv ====
// Host-side serial master model that frames commands and captures results
`default_nettype none
module tsq_host #(
  parameter int HALF = 24
) (
  // Clock
  input  wire logic        ref_clk,
  // Serial pins
  output logic             serial_clk,
  output logic             chip_sel_n,
  output logic             cmd_in,
  input  wire logic        busy_out,
  input  wire logic        result_out,
  // Observed device state
  input  wire logic [3:0]  plates,
  input  wire logic [3:0]  route,
  input  wire logic        track_en,
  input  wire logic [1:0]  pwr,
  // Transfer report
  output logic             done,
  output logic [28:0]      snap
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [11:0] res;
  logic [3:0]  ptrk;
  logic [3:0]  pcnv;
  logic [3:0]  rt;
  logic        b8;
  logic        b9;
  logic        trk;

  initial begin
    serial_clk = 1'b0;
    chip_sel_n = 1'b1;
    cmd_in     = 1'b0;
    done       = 1'b0;
    snap       = '0;
  end

  // Half period of 24 cycles keeps three clocks of tracking above 1.428 us
  // and a 24-clock frame well under the 125 kHz conversion rate
  task automatic settle();
    repeat (HALF - 1) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Clocks nrise serial periods; a short nrise abandons the frame
  task automatic frame(input logic [7:0] cmd, input int nrise, input int nbits);
    int j;
    @(posedge ref_clk);
    chip_sel_n <= 1'b0;
    cmd_in <= cmd[7];
    res = '0;
    for (j = 1; j <= nrise; j++) begin
      settle();
      if (j == 8) begin
        b8 = busy_out;
        trk = track_en;
        ptrk = plates;
        rt = route;
      end
      if (j == 9) begin
        b9 = busy_out;
        pcnv = plates;
      end
      if (j >= 10 && j <= 9 + nbits) res = {res[10:0], result_out};
      @(posedge ref_clk);
      serial_clk <= 1'b1;
      settle();
      @(posedge ref_clk);
      serial_clk <= 1'b0;
      cmd_in <= (j < 8) ? cmd[7 - j] : 1'b0;
    end
    settle();
    snap = {res, b8, b9, ptrk, pcnv, trk, rt, pwr};
    @(posedge ref_clk);
    chip_sel_n <= 1'b1;
    if (nbits > 0) done <= 1'b1;
    @(posedge ref_clk);
    done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the touch converter serial sequencer
`default_nettype none
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tsq_pkg::*;

  logic        ref_clk = 1'b0;
  logic        rst_n;
  logic        code_valid;
  logic [11:0] code_data;
  wire         serial_clk, chip_sel_n, cmd_in, busy_out, busy_oe, result_out, result_oe;
  wire         x_plus, x_minus, y_plus, y_minus, track_en, code_ready, done;
  wire         ref_power_bit, adc_power_bit, conv_start;
  tsq_ain_t    ain_pos_sel;
  tsq_neg_t    ain_neg_sel;
  tsq_ref_t    ref_sel;
  wire [28:0]  snap;
  int          mismatches = 0;
  int          num_checks = 0;
  int          i;
  logic [28:0] e;
  logic [28:0] expq[$];
  logic [11:0] fq[$];
  logic [7:0]  cx;
  logic [7:0]  cq[$];
  int          nconv = 0;
  int          nrun = 0;

  always #5 ref_clk = ~ref_clk;

  tsq_sequencer tsq_sequencer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1),
    .serial_clk(serial_clk), .chip_sel_n(chip_sel_n), .cmd_in(cmd_in),
    .busy_out(busy_out), .busy_oe(busy_oe), .result_out(result_out),
    .result_oe(result_oe), .x_plus(x_plus), .x_minus(x_minus), .y_plus(y_plus),
    .y_minus(y_minus), .ain_pos_sel(ain_pos_sel), .ain_neg_sel(ain_neg_sel),
    .ref_sel(ref_sel), .track_en(track_en), .conv_start(conv_start),
    .ref_power_bit(ref_power_bit),
    .adc_power_bit(adc_power_bit), .code_valid(code_valid), .code_ready(code_ready),
    .code_data(code_data));

  tsq_host tsq_host_inst (.ref_clk(ref_clk), .serial_clk(serial_clk),
    .chip_sel_n(chip_sel_n), .cmd_in(cmd_in), .busy_out(busy_out),
    .result_out(result_out), .plates({x_plus, x_minus, y_plus, y_minus}),
    .route({ain_neg_sel, ref_sel}), .track_en(track_en),
    .pwr({ref_power_bit, adc_power_bit}), .done(done), .snap(snap));

  // Expected snapshot: code, busy pair, plates, tracking, routing, power bits
  function automatic logic [28:0] model(logic [7:0] cmd, logic [11:0] code);
    logic [3:0] p;
    logic [3:0] rt;
    case (cmd[6:4])
      3'h1: p = 4'b0011;
      3'h3, 3'h4: p = 4'b0110;
      3'h5: p = 4'b1100;
      default: p = 4'b0000;
    endcase
    rt = {TSQ_NEG_GND, TSQ_REF_VREF};
    if (!cmd[2] && cmd[6:4] == 3'h1) rt = {TSQ_NEG_YN, TSQ_REF_YP_YN};
    if (!cmd[2] && (cmd[6:4] == 3'h3 || cmd[6:4] == 3'h4)) rt = {TSQ_NEG_XN, TSQ_REF_YP_XN};
    if (!cmd[2] && cmd[6:4] == 3'h5) rt = {TSQ_NEG_XN, TSQ_REF_XP_XN};
    return {cmd[3] ? {4'h0, code[11:4]} : code, 2'b01, p, cmd[2] ? 4'h0 : p, 1'b1, rt,
            cmd[1:0]};
  endfunction

  // Converter input per channel; channel six swaps to the second auxiliary input
  function automatic tsq_ain_t ain_exp(logic [7:0] cmd);
    case (cmd[6:4])
      3'h0: return TSQ_AIN_TEMP0;
      3'h1, 3'h3: return TSQ_AIN_XP;
      3'h2: return TSQ_AIN_VBAT;
      3'h4: return TSQ_AIN_YN;
      3'h5: return TSQ_AIN_YP;
      3'h6: return cmd[2] ? TSQ_AIN_IN1 : TSQ_AIN_IN2;
      default: return TSQ_AIN_TEMP1;
    endcase
  endfunction

  task automatic push(input logic [11:0] v);
    int n;
    @(posedge ref_clk);
    code_valid <= 1'b1;
    code_data <= v;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (code_ready !== 1'b1 && n < 100);
    code_valid <= 1'b0;
    fq.push_back(v);
  endtask

  // An empty queue sends the zero code
  task automatic run(input logic [7:0] cmd);
    logic [11:0] c;
    c = (fq.size() > 0) ? fq.pop_front() : 12'h000;
    expq.push_back(model(cmd, c));
    cq.push_back(cmd);
    nrun++;
    tsq_host_inst.frame(cmd, 24, cmd[3] ? 8 : 12);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (done === 1'b1) begin
      e = expq.pop_front();
      cx = cq.pop_front();
      `CHK("input select", ain_exp(cx), ain_pos_sel)
      `CHK("result code", e[28:17], snap[28:17])
      `CHK("busy window", e[16:15], snap[16:15])
      `CHK("plates tracking", e[14:11], snap[14:11])
      `CHK("plates converting", e[10:7], snap[10:7])
      `CHK("tracking", e[6], snap[6])
      `CHK("routing", e[5:2], snap[5:2])
      `CHK("power bits", e[1:0], snap[1:0])
    end
  end

  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) nconv++;
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    code_valid = 1'b0;
    code_data = 12'h000;
    void'($urandom(32'h37bc));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("busy_oe idle", 1'b0, busy_oe)
    `CHK("result_oe idle", 1'b0, result_oe)
    // Fill the buffer until it refuses, then drain it through real frames
    for (i = 0; i < 4; i++) push(12'($urandom));
    @(negedge ref_clk);
    `CHK("code_ready full", 1'b0, code_ready)
    // Every channel in both modes; every third frame from the seventh on finds the buffer dry
    for (i = 0; i < 16; i++) begin
      if (i >= 4 && i % 3 != 0) push(12'($urandom));
      run({1'b1, i[3:1], 1'($urandom), i[0], 2'($urandom)});
    end
    push(12'hFFF);
    run(8'hD0);
    push(12'h001);
    run(8'h94);
    push(12'($urandom));
    run(8'hB0);
    push(12'($urandom));
    run(8'hC0);
    // Abandoned frame must not consume the queued code
    push(12'($urandom));
    tsq_host_inst.frame(8'hD1, 6, 0);
    run(8'hD1);
    for (i = 0; i < 6; i++) begin
      push(12'($urandom));
      run({1'b1, 7'($urandom)});
    end
    repeat (10) @(posedge ref_clk);
    `CHK("conversions", nrun, nconv)
    wrap_up();
  end
endmodule
`default_nettype wire
